/* File: seep_pkg.sv */
/*
 seep_pkg: constants for the serial eeprom command front end.
 assumes a 10 MHz system clock sampling the serial link pins.
*/
`default_nettype none
package seep_pkg;
   localparam int unsigned CLK_MHZ      = 10;
   localparam int unsigned CSL_NS       = 250;
   localparam int unsigned CSL_CYC      = (CSL_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WORD_MS      = 5;
   localparam int unsigned ERASE_ALL_MS = 6;
   localparam int unsigned WRITE_ALL_MS = 15;
   localparam int unsigned WORD_CYC     = WORD_MS * CLK_MHZ * 1000;
   localparam int unsigned ERASE_ALL_CMD_CYC     = ERASE_ALL_MS * CLK_MHZ * 1000;
   localparam int unsigned WRITE_ALL_CMD_CYC     = WRITE_ALL_MS * CLK_MHZ * 1000;
   localparam int unsigned MEM_BYTES    = 1024;
   localparam int unsigned FIFO_DEPTH   = 32;
   localparam int unsigned FIFO_WIDTH   = 16;
   // frame lengths in rising edges, start bit included
   localparam logic [4:0]  LEN16_DATA   = 5'h1D;
   localparam logic [4:0]  LEN16_CMD    = 5'h0D;
   localparam logic [4:0]  LEN8_DATA    = 5'h16;
   localparam logic [4:0]  LEN8_CMD     = 5'h0E;
   localparam logic [1:0]  OP_EXT       = 2'h0;
   localparam logic [1:0]  OP_WRITE     = 2'h1;
   localparam logic [1:0]  OP_READ      = 2'h2;
   localparam logic [1:0]  OP_ERASE     = 2'h3;
   localparam logic [1:0]  EXT_DIS      = 2'h0;
   localparam logic [1:0]  EXT_WRITE_ALL_CMD     = 2'h1;
   localparam logic [1:0]  EXT_ERASE_ALL_CMD     = 2'h2;
   localparam logic [1:0]  EXT_EN       = 2'h3;
   localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
   localparam logic [4:0]  EDGE_ONE     = 5'h1;
endpackage : seep_pkg
`default_nettype wire

/* File: seep_top.sv */
/*
 seep_top: serial eeprom command front end with a 32-word read FIFO.
 assumes the link pins are asynchronous to mclk and the link clock
 is far slower than mclk, so each link edge spans many mclk cycles.
*/
// How it works
// - start bit is the first link rising edge seeing select and input high
// - before a start bit, clock and input activity does nothing
// - raising select leaves standby at once
// - an instruction runs after all its bits arrived, except erase and erase all, which start one edge before
// - opcode, address and data sampled on link rising edges
// - word size select high gives 16-bit words, low 8-bit
// - 16-bit frames: 9-bit address, 29 or 13 edges
// - 8-bit frames: 10-bit address, 22 or 14 edges
// - opcode 10 reads, 01 writes, 11 erases one word
// - opcode 00 plus two bits: enable, erase all, write all, disable
// - output floats except for read data or status
// - status low while busy, high when ready
// - output released on every select falling edge
// - programming disabled after reset until enable command
// - program enable input low blocks every array write
// - erase sets the word to ones, starting an edge early
// - select rising after 250 ns low in a cycle shows status
// - start bit then select low clears the status display
// - erase all sets the array to ones, starting an edge early
// - word cycle within 5 ms
// - erase all within 6 ms, write all within 15 ms
// - select low resets control, running program cycle completes
// - read sends a zero then words, continuing while selected
// - write takes 8 or 16 data bits, cycle starts on last one
// - enable holds until disable; reads ignore both
`timescale 1ns/1ps
`default_nettype none

module seep_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rptr];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst || flush) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wptr <= wptr + 1'b1;
         end
         if (pop) begin
            rptr <= rptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : seep_fifo

////////////////////////////////////////////////////////////////////////
module seep_top (
   // clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // serial link pins
   input  wire logic chip_select,
   input  wire logic serial_clk,
   input  wire logic serial_in,
   output logic      serial_out,
   output logic      serial_out_oe_n,
   // straps
   input  wire logic word_size_select,
   input  wire logic program_enable_input,
   // state
   output logic      busy
);
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_SHIFT = 4'b0010,
      ST_READ  = 4'b0100,
      ST_DONE  = 4'b1000
   } seep_state_e;

   logic [2:0]  cs_s;
   logic [2:0]  ck_s;
   logic [1:0]  di_s;
   logic [1:0]  org_s;
   logic [1:0]  pe_s;
   logic        cs;
   logic        ck_rise;
   logic        cs_fall;
   logic        cs_rise;
   seep_state_e state;
   logic [4:0]  edges;
   logic [26:0] shreg;
   logic        wide;
   logic        prog_en;
   logic [7:0]  mem [seep_pkg::MEM_BYTES];
   logic [19:0] prog_cnt;
   logic [2:0]  prog_kind;
   logic [9:0]  prog_addr;
   logic [15:0] prog_data;
   logic        show_status;
   logic [4:0]  csl_cnt;
   logic        cs_low_ok;
   logic [9:0]  rd_addr;
   logic [15:0] rd_word;
   logic [4:0]  rd_bits;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic        fifo_pop;
   logic        fetch_ok;
   logic        read_out;
   logic [4:0]  len;
   logic [3:0]  hdr;
   logic [9:0]  raddr;
   logic        prog_wide;
   logic        erase_tail;
   logic [1:0]  op;
   logic [1:0]  ext;
   logic [9:0]  faddr;
   logic [15:0] fdata;
   logic        last_edge;
   logic        early_edge;
   logic        wr_ok;

   ////////////////////////////////////////////////////////////////////
   // two flops on every pin before any logic looks at it
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cs_s  <= '0;
         ck_s  <= '0;
         di_s  <= '0;
         org_s <= '0;
         pe_s  <= '0;
      end else begin
         cs_s  <= {cs_s[1:0], chip_select};
         ck_s  <= {ck_s[1:0], serial_clk};
         di_s  <= {di_s[0], serial_in};
         org_s <= {org_s[0], word_size_select};
         pe_s  <= {pe_s[0], program_enable_input};
      end
   end
   assign cs      = cs_s[1];
   assign ck_rise = ck_s[1] && !ck_s[2];
   assign cs_fall = cs_s[2] && !cs_s[1];
   assign cs_rise = cs_s[1] && !cs_s[2];

   ////////////////////////////////////////////////////////////////////
   // frame decode
   // opcode and the two bits after it, captured as they arrive
   assign op    = hdr[3:2];
   assign ext   = hdr[1:0];
   // read frames end with the address; data then flows out
   assign len   = wide ? ((op == seep_pkg::OP_WRITE ||
                           (op == seep_pkg::OP_EXT &&
                            ext == seep_pkg::EXT_WRITE_ALL_CMD))
                          ? seep_pkg::LEN16_DATA : seep_pkg::LEN16_CMD)
                        : ((op == seep_pkg::OP_WRITE ||
                           (op == seep_pkg::OP_EXT &&
                            ext == seep_pkg::EXT_WRITE_ALL_CMD))
                          ? seep_pkg::LEN8_DATA : seep_pkg::LEN8_CMD);
   // the edge about to complete, counted from the start bit as 1
   assign last_edge  = (state == ST_SHIFT) && ck_rise &&
                       (edges + seep_pkg::EDGE_ONE == len);
   // erase and erase all start one edge before the last bit
   assign early_edge = (state == ST_SHIFT) && ck_rise &&
                       (edges + 5'h2 == len) &&
                       (op == seep_pkg::OP_ERASE ||
                        (op == seep_pkg::OP_EXT &&
                         ext == seep_pkg::EXT_ERASE_ALL_CMD));
   assign wr_ok = prog_en && pe_s[1] && (prog_kind == 3'h0);
   // address bits sit right after the opcode and the spare bit
   // write frames: address sits ahead of the data bits
   assign faddr = wide ? {1'b0, shreg[23:15]} : shreg[16:7];
   // command frames: address ends with the bit on the pin now
   assign raddr = wide ? {1'b0, shreg[7:0], di_s[1]}
                       : {shreg[8:0], di_s[1]};
   assign fdata = wide ? {shreg[14:0], di_s[1]}
                       : {8'h00, shreg[6:0], di_s[1]};

   ////////////////////////////////////////////////////////////////////
   // link state: select low holds control in reset
   always_ff @(posedge mclk) begin
      if (!nrst || !cs) begin
         state <= ST_IDLE;
         edges <= '0;
         shreg <= '0;
         hdr   <= '0;
         wide  <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (ck_rise && di_s[1]) begin
                  state <= ST_SHIFT;
                  edges <= seep_pkg::EDGE_ONE;
                  wide  <= org_s[1];
               end
            end
            ST_SHIFT: begin
               if (ck_rise) begin
                  shreg <= {shreg[25:0], di_s[1]};
                  if (edges < 5'h5) begin
                     hdr <= {hdr[2:0], di_s[1]};
                  end
                  edges <= edges + seep_pkg::EDGE_ONE;
                  if (last_edge) begin
                     state <= (op == seep_pkg::OP_READ) ? ST_READ
                                                        : ST_DONE;
                  end
               end
            end
            ST_READ: begin
            end
            ST_DONE: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // programming enable latch
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prog_en <= 1'b0;
      end else if (last_edge && op == seep_pkg::OP_EXT) begin
         if (ext == seep_pkg::EXT_EN) begin
            prog_en <= 1'b1;
         end else if (ext == seep_pkg::EXT_DIS) begin
            prog_en <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // self-timed program cycle; kind 1 word, 2 erase all, 3 write all
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prog_cnt  <= '0;
         prog_kind <= '0;
         prog_addr <= '0;
         prog_data <= '0;
      end else if (prog_kind != 3'h0) begin
         // erase starts before its final address bit has arrived
         if (erase_tail && last_edge) begin
            prog_addr <= raddr;
         end
         if (prog_cnt > 20'h1) begin
            prog_cnt <= prog_cnt - 20'h1;
         end else begin
            prog_cnt  <= '0;
            prog_kind <= '0;
         end
      end else if (wr_ok && early_edge) begin
         prog_addr <= raddr;
         prog_data <= {seep_pkg::ERASED_BYTE, seep_pkg::ERASED_BYTE};
         if (op == seep_pkg::OP_ERASE) begin
            prog_kind <= 3'h1;
            prog_cnt  <= 20'(seep_pkg::WORD_CYC);
         end else begin
            prog_kind <= 3'h2;
            prog_cnt  <= 20'(seep_pkg::ERASE_ALL_CMD_CYC);
         end
      end else if (wr_ok && last_edge && op == seep_pkg::OP_WRITE) begin
         prog_kind <= 3'h1;
         prog_addr <= faddr;
         prog_data <= fdata;
         prog_cnt  <= 20'(seep_pkg::WORD_CYC);
      end else if (wr_ok && last_edge && op == seep_pkg::OP_EXT &&
                   ext == seep_pkg::EXT_WRITE_ALL_CMD) begin
         prog_kind <= 3'h3;
         prog_data <= fdata;
         prog_cnt  <= 20'(seep_pkg::WRITE_ALL_CMD_CYC);
      end
   end
   assign busy = (prog_kind != 3'h0);

   // word size held for the cycle, select low clears wide
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prog_wide <= 1'b0;
      end else if (!busy) begin
         prog_wide <= wide;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst || !cs) begin
         erase_tail <= 1'b0;
      end else if (wr_ok && early_edge && op == seep_pkg::OP_ERASE) begin
         erase_tail <= 1'b1;
      end else if (last_edge) begin
         erase_tail <= 1'b0;
      end
   end

   // array updated on the final cycle count
   generate
      for (genvar g = 0; g < seep_pkg::MEM_BYTES; g++) begin : g_cell
         always_ff @(posedge mclk) begin
            if (busy && prog_cnt == 20'h1) begin
               if (prog_kind != 3'h1) begin
                  mem[g] <= (prog_wide && g % 2 == 0) ? prog_data[15:8]
                                                      : prog_data[7:0];
               end else if (prog_wide && (g / 2) == int'(prog_addr)) begin
                  mem[g] <= (g % 2 == 0) ? prog_data[15:8]
                                         : prog_data[7:0];
               end else if (!prog_wide && g == int'(prog_addr)) begin
                  mem[g] <= prog_data[7:0];
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // status display: select low long enough during a cycle, then high
   always_ff @(posedge mclk) begin
      if (!nrst || cs) begin
         csl_cnt <= '0;
      end else if (csl_cnt != 5'(seep_pkg::CSL_CYC)) begin
         csl_cnt <= csl_cnt + 5'h1;
      end
   end
   assign cs_low_ok = (csl_cnt == 5'(seep_pkg::CSL_CYC));

   always_ff @(posedge mclk) begin
      if (!nrst || cs_fall) begin
         show_status <= 1'b0;
      end else if (cs_rise && busy && cs_low_ok) begin
         show_status <= 1'b1;
      end else if (state == ST_SHIFT && !busy) begin
         show_status <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path: words prefetched into the fifo, shifted on link edges
   assign fetch_ok = (state == ST_READ) && fifo_in_ready;
   always_ff @(posedge mclk) begin
      if (!nrst || !cs) begin
         rd_addr <= '0;
      end else if (last_edge && op == seep_pkg::OP_READ) begin
         rd_addr <= raddr;
      end else if (fetch_ok) begin
         rd_addr <= rd_addr + 10'h1;
      end
   end

   seep_fifo #(
      .WIDTH (seep_pkg::FIFO_WIDTH),
      .DEPTH (seep_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .nrst      (nrst),
      .flush     (!cs),
      .in_valid  (state == ST_READ),
      .in_ready  (fifo_in_ready),
      .in_data   (wide ? {mem[{rd_addr[8:0], 1'b0}],
                          mem[{rd_addr[8:0], 1'b1}]}
                       : {8'h00, mem[rd_addr]}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // rd_bits counts bits left in rd_word; zero bit goes first
   assign fifo_pop = read_out && ck_rise && rd_bits == 5'h0 &&
                     fifo_out_valid;
   always_ff @(posedge mclk) begin
      if (!nrst || !cs) begin
         read_out <= 1'b0;
         rd_word  <= '0;
         rd_bits  <= '0;
         serial_out <= 1'b0;
      end else if (last_edge && op == seep_pkg::OP_READ) begin
         read_out   <= 1'b1;
         serial_out <= 1'b0;
      end else if (read_out && ck_rise) begin
         if (rd_bits != 5'h0) begin
            serial_out <= rd_word[15];
            rd_word    <= {rd_word[14:0], 1'b0};
            rd_bits    <= rd_bits - 5'h1;
         end else if (fifo_out_valid) begin
            serial_out <= wide ? fifo_out_data[15] : fifo_out_data[7];
            rd_word    <= wide ? {fifo_out_data[14:0], 1'b0}
                               : {fifo_out_data[6:0], 9'h000};
            rd_bits    <= wide ? 5'hF : 5'h7;
         end
      end else if (!read_out) begin
         serial_out <= !busy;
      end
   end

   assign serial_out_oe_n = !(read_out || show_status);

   ////////////////////////////////////////////////////////////////////
   a_idle_no_start: assert property (@(posedge mclk) disable iff (!nrst)
      (state == ST_IDLE && !(ck_rise && di_s[1] && cs)) |=>
      state == ST_IDLE)
      else $error("left idle without a start bit");
   a_cs_low_reset: assert property (@(posedge mclk) disable iff (!nrst)
      !cs |=> state == ST_IDLE)
      else $error("control not reset while deselected");
   a_release_fall: assert property (@(posedge mclk) disable iff (!nrst)
      cs_fall |=> serial_out_oe_n)
      else $error("output still driven after select fall");
   a_pe_blocks: assert property (@(posedge mclk) disable iff (!nrst)
      (!busy && !pe_s[1]) |=> !busy)
      else $error("program cycle began with enable input low");
   a_disabled_none: assert property (@(posedge mclk) disable iff (!nrst)
      (!busy && !prog_en) |=> !busy)
      else $error("program cycle began while disabled");
   a_status_level: assert property (@(posedge mclk) disable iff (!nrst)
      (show_status && !read_out && $past(show_status)) |->
      serial_out == !$past(busy))
      else $error("status level does not match busy");
   a_float_else: assert property (@(posedge mclk) disable iff (!nrst)
      (!read_out && !show_status) |-> serial_out_oe_n)
      else $error("output driven outside read or status");
   a_done_holds: assert property (@(posedge mclk) disable iff (!nrst)
      (state == ST_DONE && cs) |=> state == ST_DONE)
      else $error("frame restarted without select cycle");
endmodule : seep_top
`default_nettype wire

/* File: seep_host.sv */
/*
 seep_host: behavioural host driving the three-wire link of seep_top.
 assumes mclk at 10 MHz; each link half period spans 4 mclk (400 ns).
*/
`timescale 1ns/1ps
`default_nettype none

module seep_host (
   // clock
   input  wire logic mclk,
   // link pins
   output logic      chip_select,
   output logic      serial_clk,
   output logic      serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n
);
   logic dout;

   // released output line floats up through a pull-up
   assign dout = serial_out_oe_n ? 1'b1 : serial_out;

   initial begin
      chip_select = 1'b0;
      serial_clk  = 1'b0;
      serial_in   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   task automatic half();
      repeat (4) @(posedge mclk);
   endtask : half

   // sends n bits msb first; got holds output seen before each edge
   task automatic xfer(input int n, input logic [31:0] bits,
                       output logic [31:0] got);
      got = '0;
      serial_clk  <= 1'b0;
      serial_in   <= 1'b0;
      chip_select <= 1'b1; // clock and input low on select
      half();
      for (int i = n - 1; i >= 0; i--) begin
         serial_in <= bits[i];
         half();
         got = {got[30:0], dout};
         serial_clk <= 1'b1;
         half();
         serial_clk <= 1'b0;
      end
      half();
      got = {got[30:0], dout};
   endtask : xfer

   // low for 600 ns, more than the minimum gap between frames
   task automatic deselect();
      chip_select <= 1'b0;
      serial_in   <= ~serial_in;
      repeat (6) @(posedge mclk);
   endtask : deselect

   task automatic select_idle();
      chip_select <= 1'b1; // clock low while selecting
      serial_clk  <= 1'b0;
      serial_in   <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask : select_idle
endmodule : seep_host
`default_nettype wire

/* File: test_seep_top.sv */
/*
 test_seep_top: self-checking bench for seep_top with a host model.
 assumes the full-length program cycle, so only one word is written.
*/
`timescale 1ns/1ps
`default_nettype none

module test_seep_top;
   logic        mclk;
   logic        nrst;
   logic        word_size_select;
   logic        program_enable_input;
   wire         chip_select;
   wire         serial_clk;
   wire         serial_in;
   wire         serial_out;
   wire         serial_out_oe_n;
   wire         busy;
   int          failures;
   int          comparisons;
   logic [31:0] seed;
   logic [31:0] got;
   logic [8:0]  wa;
   logic [15:0] wd;
   int          cnt;

   seep_top u_seep_top (.mclk(mclk), .nrst(nrst),
      .chip_select(chip_select), .serial_clk(serial_clk),
      .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n),
      .word_size_select(word_size_select),
      .program_enable_input(program_enable_input), .busy(busy));
   seep_host u_seep_host (.mclk(mclk), .chip_select(chip_select),
      .serial_clk(serial_clk), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] frame(input logic ws,
      input logic [1:0] op, input logic xb, input logic [9:0] a,
      input logic [15:0] d, input logic dat);
      logic [31:0] f;
      if (ws) f = {3'h0, 1'b1, op, xb, a[8:0], d};
      else f = {10'h0, 1'b1, op, xb, a, d[7:0]};
      return dat ? f : f >> (ws ? 16 : 8);
   endfunction : frame

   function automatic int flen(input logic ws, input logic dat);
      return ws ? (dat ? 29 : 13) : (dat ? 22 : 14);
   endfunction : flen

   task automatic cmp(input string what, input logic [16:0] exp,
                      input logic [16:0] seen);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp

   task automatic complete_run();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic send(input logic ws, input logic [1:0] op,
      input logic xb, input logic [9:0] a, input logic [15:0] d,
      input logic dat);
      word_size_select <= ws;
      @(posedge mclk);
      u_seep_host.xfer(flen(ws, dat), frame(ws, op, xb, a, d, dat), got);
      u_seep_host.deselect();
      cmp("oe_n_after_frame", 17'h1, 17'(serial_out_oe_n));
   endtask : send

   task automatic ext(input logic ws, input logic [1:0] sub,
                      input logic dat);
      send(ws, seep_pkg::OP_EXT, sub[1], {sub[0], sub[0], 8'($random(seed))},
           16'($random(seed)), dat);
   endtask : ext

   // leading idle edges with input low must not start a frame
   task automatic rd(input logic ws, input logic [9:0] a, input int extra,
                     input logic [16:0] exp);
      int lead;
      lead = $random(seed) & 1;
      word_size_select <= ws;
      @(posedge mclk);
      u_seep_host.xfer(lead + flen(ws, 1'b1) + extra,
         frame(ws, seep_pkg::OP_READ, 1'b0, a, 16'h0, 1'b1) << extra, got);
      u_seep_host.deselect();
      cmp("read_data", exp, got[16:0]);
   endtask : rd

   ////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      word_size_select = 1'b1;
      program_enable_input = 1'b1;
      failures = 0;
      comparisons = 0;
      seed = 32'hebc61a6f;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      cmp("oe_n_idle", 17'h1, 17'(serial_out_oe_n));
      // every programming code refused while disabled, both widths
      for (int k = 0; k < 8; k++) begin
         case (k[2:1])
            2'h0: send(k[0], seep_pkg::OP_WRITE, 1'b0,
                       10'($random(seed)), 16'($random(seed)), 1'b1);
            2'h1: send(k[0], seep_pkg::OP_ERASE, 1'b0,
                       10'($random(seed)), 16'h0, 1'b0);
            2'h2: ext(k[0], seep_pkg::EXT_ERASE_ALL_CMD, 1'b0);
            default: ext(k[0], seep_pkg::EXT_WRITE_ALL_CMD, 1'b1);
         endcase
         cmp("busy_disabled", 17'h0, 17'(busy));
      end
      ext(1'b1, seep_pkg::EXT_EN, 1'b0);
      program_enable_input <= 1'b0;
      wa = 9'($random(seed));
      wd = 16'($random(seed));
      send(1'b1, seep_pkg::OP_WRITE, 1'b0, {1'b0, wa}, wd, 1'b1);
      cmp("busy_pin_low", 17'h0, 17'(busy));
      program_enable_input <= 1'b1;
      send(1'b1, seep_pkg::OP_WRITE, 1'b0, {1'b0, wa}, wd, 1'b1);
      cmp("busy_write", 17'h1, 17'(busy));
      u_seep_host.select_idle();
      cmp("status_busy", 17'h0, {15'h0, serial_out_oe_n, serial_out});
      cnt = 0;
      while (busy !== 1'b0 && cnt < 60000) begin
         @(posedge mclk);
         cnt++;
      end
      cmp("cycle_done", 17'h0, 17'(busy));
      repeat (6) @(posedge mclk);
      cmp("status_ready", 17'h1, {15'h0, serial_out_oe_n, serial_out});
      u_seep_host.deselect();
      u_seep_host.xfer(1, 32'h1, got);
      u_seep_host.deselect();
      u_seep_host.select_idle();
      cmp("status_cleared", 17'h1, 17'(serial_out_oe_n));
      u_seep_host.deselect();
      ext(1'b1, seep_pkg::EXT_DIS, 1'b0);
      send(1'b1, seep_pkg::OP_WRITE, 1'b0, {1'b0, wa}, ~wd, 1'b1);
      cmp("busy_after_dis", 17'h0, 17'(busy));
      rd(1'b1, {1'b0, wa}, 0, {1'b0, wd});
      rd(1'b0, {wa, 1'b0}, 8, {1'b0, wd});
      complete_run();
   end

   initial begin
      repeat (70000) @(posedge mclk);
      failures++;
      complete_run();
   end
endmodule : test_seep_top
`default_nettype wire
